// File: rgcta_config.v
// General configuration store and trip output mapping of a protection relay.
// Assumes one-cycle write strobes from keypad or serial front ends on CLK_I.
// Behaviour
// - Unit identifier is held as a value 0 to 9999.
// - Serial session opens only with a matching unit identifier.
// - Unit identifier changes accepted only from the keypad.
// - Line frequency accepts only 50 or 60 hertz.
// - New line frequency stays pending until power re-initialisation.
// - Phase sequence is forward or reverse, used to label faulted phases.
// - Time sync 0 free-runs locally, 1 disciplines from IRIG-B input.
// - One breaker: commands drive breaker one outputs only.
// - Two breakers: commands carry selector choosing breaker one or two.
// - Trip outputs map to coils by breaker count and circuits per breaker.
// - One breaker, one circuit releases trip outputs two to four.
// - Outputs three and four trip only for two breakers with two circuits.
// - Manual trip from keypad or serial when enabled, via the mapping.
// - Monitored output with absent voltage while not tripping records an open circuit event.
// - Open trip circuit optionally closes an alarm output.
// - Trip without voltage drop raises alarm; a drop raises none.
// - Monitoring selectable per output regardless of trip assignment.
// - Monitor mask bit three is output four, bit zero output one.
// - Four setting groups, chosen by keypad, serial or contacts.
// - General settings apply the same whatever group is active.
`timescale 1ns/1ps
`include "rgcta_map.vh"
module rgcta_config #(
  parameter DROP_CYCLES = `RGCTA_DROP_CYCLES
)(
  input wire CLK_I,
  input wire RST_B_I,
  input wire POWER_INIT_I,
  input wire WR_I,
  input wire [1:0] WR_SRC_I,
  input wire [2:0] WR_SEL_I,
  input wire [13:0] WR_DATA_I,
  input wire SESSION_REQ_I,
  input wire [13:0] SESSION_ID_I,
  input wire MANUAL_TRIP_EN_I,
  input wire TRIP_CMD_I,
  input wire CLOSE_CMD_I,
  input wire CMD_FROM_SERIAL_I,
  input wire CMD_BKR_SEL_I,
  input wire PROT_TRIP_I,
  input wire [3:0] LOGIC_OUT_I,
  input wire [3:0] VOLT_OK_I,
  input wire ALARM_EN_I,
  input wire IRIG_PULSE_I,
  input wire LOCAL_TICK_I,
  input wire FAULT_PHASE_A_I,
  input wire FAULT_PHASE_C_I,
  output reg WR_ACK_O,
  output reg WR_REJECT_O,
  output reg SESSION_OPEN_O,
  output reg [13:0] UNIT_ID_O,
  output reg FREQ_60_O,
  output reg FREQ_PENDING_60_O,
  output reg PHASE_REVERSE_O,
  output reg TIME_SYNC_IRIG_O,
  output reg BKR_TWO_O,
  output reg TC_TWO_O,
  output reg [3:0] MON_MASK_O,
  output reg [1:0] ACTIVE_GROUP_O,
  output reg [3:0] TRIP_OUT_O,
  output reg [3:0] TRIP_ASSIGNED_O,
  output reg [1:0] CLOSE_OUT_O,
  output reg TIME_TICK_O,
  output reg [1:0] FAULT_LABEL_O,
  output reg [3:0] OPEN_EVENT_O,
  output reg [3:0] NO_DROP_ALARM_O,
  output reg ALARM_O
);
  wire [3:0] open_event;
  wire [3:0] open_level;
  wire [3:0] no_drop;
  reg [3:0] next_trip;
  reg [3:0] next_assigned;
  reg [3:0] coil_first;
  reg [3:0] coil_second;
  reg next_ok;
  wire manual_trip;
  wire cmd_bkr_two;

  ////////////////////////////////////////////////////////////////////////////
  // Write validation: only legal values for each selector get through.
  always @*
  begin
    next_ok = 1'b0;
    case (WR_SEL_I)
      `RGCTA_SEL_UNIT_ID:
        next_ok = (WR_SRC_I == `RGCTA_SRC_KEYPAD) &&
          (WR_DATA_I <= `RGCTA_UNIT_ID_MAX);
      `RGCTA_SEL_LINE_FREQ:
        next_ok = (WR_DATA_I == {7'h00, `RGCTA_FREQ_50}) ||
          (WR_DATA_I == {7'h00, `RGCTA_FREQ_60});
      `RGCTA_SEL_PHASE_SEQ, `RGCTA_SEL_TIME_SYNC:
        next_ok = (WR_DATA_I[13:1] == 13'h0000);
      `RGCTA_SEL_BKR_COUNT, `RGCTA_SEL_TC_PER_BKR:
        next_ok = (WR_DATA_I == 14'h0001) || (WR_DATA_I == 14'h0002);
      `RGCTA_SEL_MON_MASK:
        next_ok = (WR_DATA_I[13:4] == 10'h000);
      `RGCTA_SEL_GROUP:
        next_ok = (WR_DATA_I[13:2] == 12'h000);
      default:
        next_ok = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Setting store. General settings are kept apart from the group select so
  // a group change never touches them.
  always @(posedge CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
    begin
      WR_ACK_O <= 1'b0;
      WR_REJECT_O <= 1'b0;
      UNIT_ID_O <= `RGCTA_RST_UNIT_ID;
      FREQ_60_O <= `RGCTA_RST_FREQ_60;
      FREQ_PENDING_60_O <= `RGCTA_RST_FREQ_60;
      PHASE_REVERSE_O <= `RGCTA_RST_PHASE_SEQ;
      TIME_SYNC_IRIG_O <= `RGCTA_RST_TIME_SYNC;
      BKR_TWO_O <= `RGCTA_RST_BKR_TWO;
      TC_TWO_O <= `RGCTA_RST_TC_TWO;
      MON_MASK_O <= `RGCTA_RST_MON_MASK;
      ACTIVE_GROUP_O <= `RGCTA_RST_GROUP;
    end
    else
    begin
      WR_ACK_O <= WR_I && next_ok;
      WR_REJECT_O <= WR_I && !next_ok;
      if (POWER_INIT_I)
        FREQ_60_O <= FREQ_PENDING_60_O;
      if (WR_I && next_ok)
      begin
        case (WR_SEL_I)
          `RGCTA_SEL_UNIT_ID: UNIT_ID_O <= WR_DATA_I;
          `RGCTA_SEL_LINE_FREQ: FREQ_PENDING_60_O <= (WR_DATA_I[6:0] == `RGCTA_FREQ_60);
          `RGCTA_SEL_PHASE_SEQ: PHASE_REVERSE_O <= WR_DATA_I[0];
          `RGCTA_SEL_TIME_SYNC: TIME_SYNC_IRIG_O <= WR_DATA_I[0];
          `RGCTA_SEL_BKR_COUNT: BKR_TWO_O <= WR_DATA_I[1];
          `RGCTA_SEL_TC_PER_BKR: TC_TWO_O <= WR_DATA_I[1];
          `RGCTA_SEL_MON_MASK: MON_MASK_O <= WR_DATA_I[3:0];
          `RGCTA_SEL_GROUP: ACTIVE_GROUP_O <= WR_DATA_I[1:0];
          default: ACTIVE_GROUP_O <= ACTIVE_GROUP_O;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Coil map: which outputs drive each breaker's first and second coils.
  assign cmd_bkr_two = BKR_TWO_O && CMD_BKR_SEL_I;
  assign manual_trip = MANUAL_TRIP_EN_I && TRIP_CMD_I;
  always @*
  begin
    coil_first = 4'h0;
    coil_second = 4'h0;
    case ({BKR_TWO_O, TC_TWO_O})
      2'h0:
      begin
        coil_first = 4'h1;
        coil_second = 4'h0;
      end
      2'h1:
      begin
        coil_first = 4'h3;
        coil_second = 4'h0;
      end
      2'h2:
      begin
        coil_first = 4'h1;
        coil_second = 4'h2;
      end
      2'h3:
      begin
        coil_first = 4'h3;
        coil_second = 4'hC;
      end
      default:
      begin
        coil_first = 4'h1;
        coil_second = 4'h0;
      end
    endcase
    next_assigned = coil_first | coil_second;
    next_trip = 4'h0;
    if (PROT_TRIP_I)
      next_trip = next_assigned;
    if (manual_trip)
      next_trip = next_trip | (cmd_bkr_two ? coil_second : coil_first);
    // Released outputs are handed to the programmable logic.
    next_trip = next_trip | (LOGIC_OUT_I & ~next_assigned);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, session gate, time base and fault labelling.
  always @(posedge CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
    begin
      TRIP_OUT_O <= 4'h0;
      TRIP_ASSIGNED_O <= 4'h1;
      CLOSE_OUT_O <= 2'h0;
      SESSION_OPEN_O <= 1'b0;
      TIME_TICK_O <= 1'b0;
      FAULT_LABEL_O <= 2'h0;
      OPEN_EVENT_O <= 4'h0;
      NO_DROP_ALARM_O <= 4'h0;
      ALARM_O <= 1'b0;
    end
    else
    begin
      TRIP_OUT_O <= next_trip;
      TRIP_ASSIGNED_O <= next_assigned;
      CLOSE_OUT_O <= {CLOSE_CMD_I && cmd_bkr_two, CLOSE_CMD_I && !cmd_bkr_two};
      // A session holds only while requested with the right identifier.
      SESSION_OPEN_O <= SESSION_REQ_I && (SESSION_ID_I == UNIT_ID_O);
      TIME_TICK_O <= TIME_SYNC_IRIG_O ? IRIG_PULSE_I : LOCAL_TICK_I;
      // Label bit 1 marks the lagging-phase name swapped for reverse rotation.
      FAULT_LABEL_O <= PHASE_REVERSE_O ? {FAULT_PHASE_C_I, FAULT_PHASE_A_I}
        : {FAULT_PHASE_A_I, FAULT_PHASE_C_I};
      OPEN_EVENT_O <= open_event;
      NO_DROP_ALARM_O <= no_drop;
      ALARM_O <= (ALARM_EN_I && (|open_level)) || (|no_drop);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // One supervisor per output, gated only by its own mask bit.
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : mon
      rgcta_trip_mon #(
        .DROP_CYCLES(DROP_CYCLES)
      ) u_mon (
        .clk_i(CLK_I),
        .rst_b_i(RST_B_I),
        .enable_i(MON_MASK_O[g]),
        .trip_i(TRIP_OUT_O[g]),
        .volt_ok_i(VOLT_OK_I[g]),
        .open_event_o(open_event[g]),
        .open_level_o(open_level[g]),
        .no_drop_alarm_o(no_drop[g])
      );
    end
  endgenerate
endmodule

// File: rgcta_map.vh
// Constants for the relay general configuration and trip assignment block.
// Included by the design files; holds definitions only.
`ifndef RGCTA_MAP_VH
`define RGCTA_MAP_VH
// Setting selectors on the write port.
`define RGCTA_SEL_UNIT_ID 3'h0
`define RGCTA_SEL_LINE_FREQ 3'h1
`define RGCTA_SEL_PHASE_SEQ 3'h2
`define RGCTA_SEL_TIME_SYNC 3'h3
`define RGCTA_SEL_BKR_COUNT 3'h4
`define RGCTA_SEL_TC_PER_BKR 3'h5
`define RGCTA_SEL_MON_MASK 3'h6
`define RGCTA_SEL_GROUP 3'h7
// Write sources.
`define RGCTA_SRC_KEYPAD 2'h0
`define RGCTA_SRC_SERIAL 2'h1
`define RGCTA_SRC_CONTACT 2'h2
// Limits and encodings.
`define RGCTA_UNIT_ID_MAX 14'h270F
`define RGCTA_FREQ_50 7'h32
`define RGCTA_FREQ_60 7'h3C
// Reset values.
`define RGCTA_RST_UNIT_ID 14'h0000
`define RGCTA_RST_FREQ_60 1'h1
`define RGCTA_RST_PHASE_SEQ 1'h0
`define RGCTA_RST_TIME_SYNC 1'h0
`define RGCTA_RST_BKR_TWO 1'h0
`define RGCTA_RST_TC_TWO 1'h0
`define RGCTA_RST_MON_MASK 4'h0
`define RGCTA_RST_GROUP 2'h0
// Clock rate and trip-drop supervision window.
`define RGCTA_CLK_HZ 10000000
`define RGCTA_DROP_WINDOW_US 1000
`define RGCTA_DROP_CYCLES ((`RGCTA_DROP_WINDOW_US * (`RGCTA_CLK_HZ / 1000000)))
`endif

// File: rgcta_trip_mon.v
// One trip circuit supervisor for a single trip output.
// Assumes a synchronous voltage-present input and a trip drive from the same clock.
`timescale 1ns/1ps
`include "rgcta_map.vh"
module rgcta_trip_mon #(
  parameter DROP_CYCLES = 10000
)(
  input wire clk_i,
  input wire rst_b_i,
  input wire enable_i,
  input wire trip_i,
  input wire volt_ok_i,
  output reg open_event_o,
  output reg open_level_o,
  output reg no_drop_alarm_o
);
  reg trip_d;
  reg [15:0] drop_cnt;
  reg waiting;

  ////////////////////////////////////////////////////////////////////////////
  // Open circuit is judged only while not tripping, since a closed contact
  // also shows no voltage. A trip that fails to collapse the voltage within
  // the window means the trip contact is stuck and never closed.
  always @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      trip_d <= 1'b0;
      drop_cnt <= 16'h0000;
      waiting <= 1'b0;
      open_event_o <= 1'b0;
      open_level_o <= 1'b0;
      no_drop_alarm_o <= 1'b0;
    end
    else
    begin
      trip_d <= trip_i;
      open_event_o <= 1'b0;
      no_drop_alarm_o <= 1'b0;
      if (!enable_i || trip_i)
        open_level_o <= 1'b0;
      else
      begin
        open_level_o <= !volt_ok_i;
        if (!volt_ok_i && !open_level_o)
          open_event_o <= 1'b1;
      end
      if (enable_i && trip_i && !trip_d)
      begin
        waiting <= volt_ok_i;
        drop_cnt <= DROP_CYCLES[15:0];
      end
      else if (waiting)
      begin
        if (!volt_ok_i || !trip_i)
          waiting <= 1'b0;
        else if (drop_cnt == 16'h0001)
        begin
          waiting <= 1'b0;
          no_drop_alarm_o <= 1'b1;
        end
        else
          drop_cnt <= drop_cnt - 16'h0001;
      end
    end
  end
endmodule

// File: rgcta_config_properties.sv
// Checker for the configuration block, watching only its top ports.
// Assumes CLK_I and the asynchronous active-low RST_B_I of the block.
`timescale 1ns/1ps
module rgcta_chk (
  input wire CLK_I,
  input wire RST_B_I,
  input wire POWER_INIT_I,
  input wire WR_I,
  input wire [1:0] WR_SRC_I,
  input wire [2:0] WR_SEL_I,
  input wire SESSION_REQ_I,
  input wire [13:0] SESSION_ID_I,
  input wire [3:0] LOGIC_OUT_I,
  input wire WR_ACK_O,
  input wire WR_REJECT_O,
  input wire SESSION_OPEN_O,
  input wire [13:0] UNIT_ID_O,
  input wire FREQ_60_O,
  input wire BKR_TWO_O,
  input wire TC_TWO_O,
  input wire [3:0] MON_MASK_O,
  input wire [3:0] TRIP_OUT_O,
  input wire [3:0] TRIP_ASSIGNED_O,
  input wire [1:0] CLOSE_OUT_O,
  input wire [3:0] OPEN_EVENT_O,
  input wire [3:0] NO_DROP_ALARM_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RST_B_I);
  // Helpers keep the session compare and the dual-circuit case readable.
  wire both = BKR_TWO_O & TC_TWO_O;
  wire match = SESSION_REQ_I && (SESSION_ID_I == UNIT_ID_O);
  ////////////////////////////////////////////////////////////////////
  // Write answers come exactly once and only for a write.
  answer_once_a: assert property (
    WR_I |=> WR_ACK_O != WR_REJECT_O) else $error("write answer missing or doubled");
  answer_cause_a: assert property (
    WR_ACK_O || WR_REJECT_O |-> $past(WR_I)) else $error("answer without write");
  link_id_a: assert property (
    WR_I && WR_SEL_I == 3'h0 && WR_SRC_I != 2'h0 |=> WR_REJECT_O && $stable(UNIT_ID_O))
    else $error("unit id changed from link");
  id_range_a: assert property (
    UNIT_ID_O <= 14'h270F) else $error("unit id out of range");
  freq_hold_a: assert property (
    !POWER_INIT_I |=> $stable(FREQ_60_O)) else $error("frequency changed without init");
  session_gate_a: assert property (
    SESSION_OPEN_O == $past(match)) else $error("session state wrong");
  // Compared only once the counts have settled, so either latency style passes.
  trip_map_a: assert property (
    $stable({BKR_TWO_O, TC_TWO_O}) |-> TRIP_ASSIGNED_O == {both, both, BKR_TWO_O | TC_TWO_O, 1'b1})
    else $error("trip assignment wrong");
  free_pass_a: assert property (
    $stable(TRIP_ASSIGNED_O) |->
      (TRIP_OUT_O & ~TRIP_ASSIGNED_O) == ($past(LOGIC_OUT_I) & ~TRIP_ASSIGNED_O))
    else $error("free output not following logic");
  one_breaker_a: assert property (
    !BKR_TWO_O && !$past(BKR_TWO_O) |-> !CLOSE_OUT_O[1]) else $error("second close driven");
  mask_gate_a: assert property (
    (OPEN_EVENT_O & ~MON_MASK_O & ~$past(MON_MASK_O, 4)) == 4'h0) else $error("unmonitored event");
  c_reject: cover property (WR_REJECT_O);
  c_open: cover property (|OPEN_EVENT_O);
  c_nodrop: cover property (|NO_DROP_ALARM_O);
endmodule
bind rgcta_config rgcta_chk rgcta_chk_i (.CLK_I(CLK_I), .RST_B_I(RST_B_I),
  .POWER_INIT_I(POWER_INIT_I), .WR_I(WR_I), .WR_SRC_I(WR_SRC_I), .WR_SEL_I(WR_SEL_I),
  .SESSION_REQ_I(SESSION_REQ_I), .SESSION_ID_I(SESSION_ID_I), .LOGIC_OUT_I(LOGIC_OUT_I),
  .WR_ACK_O(WR_ACK_O), .WR_REJECT_O(WR_REJECT_O), .SESSION_OPEN_O(SESSION_OPEN_O),
  .UNIT_ID_O(UNIT_ID_O), .FREQ_60_O(FREQ_60_O), .BKR_TWO_O(BKR_TWO_O), .TC_TWO_O(TC_TWO_O),
  .MON_MASK_O(MON_MASK_O), .TRIP_OUT_O(TRIP_OUT_O), .TRIP_ASSIGNED_O(TRIP_ASSIGNED_O),
  .CLOSE_OUT_O(CLOSE_OUT_O), .OPEN_EVENT_O(OPEN_EVENT_O), .NO_DROP_ALARM_O(NO_DROP_ALARM_O));

// File: rgcta_coils.sv
// Behavioural trip coil circuits across the four trip outputs.
// Assumes the bench commands open coils or welded contacts directly.
`timescale 1ns/1ps
module rgcta_coils (
  input wire [3:0] trip_i,
  input wire [3:0] open_i,
  input wire [3:0] stuck_i,
  output wire [3:0] volt_ok_o
);
  // An intact coil shows voltage until its contact closes; a welded contact keeps it up.
  assign volt_ok_o = ~open_i & (~trip_i | stuck_i);
endmodule

// File: rgcta_config_test.sv
// Self-checking bench for the configuration and trip assignment block.
// Assumes the coil model across the trip outputs and a 10 MHz clock.
`timescale 1ns/1ps
module rgcta_config_test;
  reg clk, rst_b, pin, wr, ses, men, tcmd, sel, prot, alen, sal;
  reg ltk, irq, fa, fc;
  wire tick;
  wire [1:0] lbl;
  reg [1:0] src;
  reg [2:0] fs;
  reg [13:0] dat, sid;
  reg [3:0] lgc, opn, stk, ev, nd, asg, ex;
  wire ack, rej, sop, f60, fp60, prv, irig, al;
  wire [13:0] uid;
  wire [3:0] msk, tout, tas, oev, nda, vok;
  wire [1:0] grp, cout;
  integer miscompares, checked, i;
  rgcta_config #(.DROP_CYCLES(8)) rgcta_config_i (.CLK_I(clk), .RST_B_I(rst_b),
    .POWER_INIT_I(pin), .WR_I(wr), .WR_SRC_I(src), .WR_SEL_I(fs), .WR_DATA_I(dat),
    .SESSION_REQ_I(ses), .SESSION_ID_I(sid), .MANUAL_TRIP_EN_I(men), .TRIP_CMD_I(tcmd),
    .CLOSE_CMD_I(tcmd), .CMD_FROM_SERIAL_I(1'b0), .CMD_BKR_SEL_I(sel), .PROT_TRIP_I(prot),
    .LOGIC_OUT_I(lgc), .VOLT_OK_I(vok), .ALARM_EN_I(alen), .IRIG_PULSE_I(irq),
    .LOCAL_TICK_I(ltk), .FAULT_PHASE_A_I(fa), .FAULT_PHASE_C_I(fc), .WR_ACK_O(ack),
    .WR_REJECT_O(rej), .SESSION_OPEN_O(sop), .UNIT_ID_O(uid), .FREQ_60_O(f60),
    .FREQ_PENDING_60_O(fp60), .PHASE_REVERSE_O(prv), .TIME_SYNC_IRIG_O(irig),
    .BKR_TWO_O(), .TC_TWO_O(), .MON_MASK_O(msk), .ACTIVE_GROUP_O(grp),
    .TRIP_OUT_O(tout), .TRIP_ASSIGNED_O(tas), .CLOSE_OUT_O(cout), .TIME_TICK_O(tick),
    .FAULT_LABEL_O(lbl), .OPEN_EVENT_O(oev), .NO_DROP_ALARM_O(nda), .ALARM_O(al));
  rgcta_coils rgcta_coils_i (.trip_i(tout), .open_i(opn), .stuck_i(stk), .volt_ok_o(vok));
  always #50 clk = ~clk;
  ////////////////////////////////////////////////////////////////////
  // Shared compare; case inequality so an unknown never passes.
  task chk(input [15:0] g, input [15:0] e);
    begin
      checked = checked + 1;
      if (g !== e)
      begin
        miscompares = miscompares + 1;
        $display("ERROR %0t got %h expected %h", $time, g, e);
      end
    end
  endtask
  // One write strobe, then the one-cycle answer.
  task wrt(input [1:0] s, input [2:0] f, input [13:0] d, input ok);
    begin
      @(posedge clk);
      wr <= 1'b1;
      src <= s;
      fs <= f;
      dat <= d;
      @(posedge clk);
      wr <= 1'b0;
      #1 chk(ack, ok);
      chk(rej, !ok);
    end
  endtask
  // Pulses are gathered over a fixed window so none is missed between samples.
  task watch(input integer n);
    integer k;
    begin
      ev = 4'h0;
      nd = 4'h0;
      sal = 1'b0;
      for (k = 0; k < n; k = k + 1)
      begin
        @(posedge clk);
        #1 ev = ev | oev;
        nd = nd | nda;
        sal = sal | al;
      end
    end
  endtask
  task drv(input p, input [3:0] l, input e, input c);
    begin
      @(posedge clk);
      prot <= p;
      lgc <= l;
      men <= e;
      tcmd <= c;
      sel <= i[0];
      watch(2);
    end
  endtask
  ////////////////////////////////////////////////////////////////////
  task t_id;
    begin
      wrt(2'h0, 3'h0, 14'h270F, 1'b1);
      wrt(2'h0, 3'h0, 14'h2710, 1'b0);
      wrt(2'h1, 3'h0, 14'h0005, 1'b0);
      chk(uid, 14'h270F);
      @(posedge clk);
      ses <= 1'b1;
      sid <= 14'h0005;
      watch(2);
      chk(sop, 1'b0);
      @(posedge clk);
      sid <= 14'h270F;
      watch(2);
      chk(sop, 1'b1);
    end
  endtask
  task t_freq;
    begin
      wrt(2'h0, 3'h1, 14'h0032, 1'b1);
      chk(fp60, 1'b0);
      chk(f60, 1'b1);
      wrt(2'h1, 3'h1, 14'h0037, 1'b0);
      @(posedge clk);
      pin <= 1'b1;
      @(posedge clk);
      pin <= 1'b0;
      watch(1);
      chk(f60, 1'b0);
    end
  endtask
  // Every breaker and circuit count, with protection, free and manual drive.
  task t_map;
    begin
      for (i = 0; i < 4; i = i + 1)
      begin
        wrt(2'h0, 3'h4, i[1] ? 14'h0002 : 14'h0001, 1'b1);
        wrt(2'h1, 3'h5, i[0] ? 14'h0002 : 14'h0001, 1'b1);
        asg = {i[1] & i[0], i[1] & i[0], i[1] | i[0], 1'b1};
        drv(1'b1, 4'h0, 1'b0, 1'b0);
        chk(tas, asg);
        chk(tout, asg);
        drv(1'b0, 4'hF, 1'b0, 1'b1);
        ex = ~asg;
        chk(tout, ex);
        chk(cout, (i == 3) ? 2'h2 : 2'h1);
        drv(1'b0, 4'h0, 1'b1, 1'b1);
        ex = (i == 3) ? 4'hC : (i[0] ? 4'h3 : 4'h1);
        chk(tout, ex);
        chk(cout, (i == 3) ? 2'h2 : 2'h1);
        drv(1'b0, 4'h0, 1'b0, 1'b0);
      end
      wrt(2'h0, 3'h4, 14'h0003, 1'b0);
    end
  endtask
  task t_mon;
    begin
      wrt(2'h0, 3'h6, 14'h0010, 1'b0);
      wrt(2'h0, 3'h6, 14'h0005, 1'b1);
      chk(msk, 4'h5);
      @(posedge clk);
      opn <= 4'h3;
      alen <= 1'b1;
      watch(8);
      chk(ev, 4'h1);
      chk(sal, 1'b1);
      @(posedge clk);
      opn <= 4'h0;
      stk <= 4'h1;
      drv(1'b1, 4'h0, 1'b0, 1'b0);
      watch(16);
      chk(nd, 4'h1);
      drv(1'b0, 4'h0, 1'b0, 1'b0);
      @(posedge clk);
      stk <= 4'h0;
      drv(1'b1, 4'h0, 1'b0, 1'b0);
      watch(16);
      chk(nd, 4'h0);
    end
  endtask
  task t_misc;
    begin
      // Local tick path and forward labelling before either setting moves.
      @(posedge clk);
      ltk <= 1'b1;
      fa <= 1'b1;
      watch(1);
      chk(tick, 1'b1);
      chk(lbl, 2'h2);
      wrt(2'h1, 3'h2, 14'h0001, 1'b1);
      chk(prv, 1'b1);
      wrt(2'h0, 3'h2, 14'h0002, 1'b0);
      wrt(2'h1, 3'h3, 14'h0001, 1'b1);
      chk(irig, 1'b1);
      // With the pulse source switched, the local tick must no longer pass.
      watch(1);
      chk(tick, 1'b0);
      chk(lbl, 2'h1);
      @(posedge clk);
      irq <= 1'b1;
      ltk <= 1'b0;
      watch(1);
      chk(tick, 1'b1);
      for (i = 0; i < 3; i = i + 1)
      begin
        wrt(i[1:0], 3'h7, i[13:0] + 14'h0001, 1'b1);
        chk(grp, i[1:0] + 2'h1);
      end
      wrt(2'h0, 3'h7, 14'h0004, 1'b0);
      chk(uid, 14'h270F);
    end
  endtask
  task final_report;
    begin
      $display("checks %0d mismatches %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  ////////////////////////////////////////////////////////////////////
  initial
  begin
    {clk, rst_b, pin, wr, ses, men, tcmd, sel, prot, alen} = 10'h000;
    {src, fs, dat, sid, lgc, opn, stk} = 45'h0;
    {ltk, irq, fa, fc} = 4'h0;
    miscompares = 0;
    checked = 0;
    i = 0;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    #1 chk(f60, 1'b1);
    chk(tas, 4'h1);
    t_id;
    t_freq;
    t_map;
    t_mon;
    t_misc;
    final_report;
  end
endmodule
